// [bench/bldc_host_model.sv]
// Purpose: register host on the byte request port
// Assumes: requests launched on the falling clock edge
// Notes: idle lines carry inverted values, never stale ones
`default_nettype none
module bldc_host_model (
    input wire logic clk,
    input wire logic rvalid,
    input wire logic [7:0] rdata,
    output var bldc_pkg::bldc_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    import bldc_pkg::*;
    // idle at time zero
    initial req = '{wr: 1'b0, rd: 1'b0, addr: 3'h7, wdata: 8'hA5};
    // one write held across one rising edge
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(negedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~v};
    endtask
    // one read, data taken while rvalid stands
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(negedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
        @(negedge clk);
        v = (rvalid === 1'b1) ? rdata : 8'hXX;
        req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req.wdata};
    endtask
endmodule
`default_nettype wire

// [bench/bldc_regs_monitor.sv]
// Purpose: port timing checks for the register bank
// Assumes: one clock, async active-high reset
// Notes: bound onto every bldc_regs instance
`default_nettype none
module bldc_regs_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire bldc_pkg::bldc_req_t req,
    input wire bldc_pkg::bldc_det_t det,
    input wire logic rvalid,
    input wire logic [3:0] string_enable,
    input wire logic overcurrent_recover_sel,
    input wire logic [2:0] short_threshold_code,
    input wire logic [3:0] switch_freq_code,
    input wire logic converter_on,
    input wire logic [7:0] full_scale_code,
    input wire logic fault_out_n_o,
    input wire logic fault_out_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    import bldc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // read handshake and register writes
    property p_rvalid; req.rd |=> rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_rv_only; rvalid |-> $past(req.rd); endproperty
    a_rv_only: assert property (p_rv_only) else $error("stray rvalid");
    property p_en_wr;
        req.wr && req.addr == ADDR_DIM_MODE |=> string_enable == $past(req.wdata[7:4]);
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("enables not written");
    property p_sw_wr; req.wr && req.addr == ADDR_SWITCH |=>
        {overcurrent_recover_sel, short_threshold_code, switch_freq_code} == $past(req.wdata);
    endproperty
    a_sw_wr: assert property (p_sw_wr) else $error("switch reg not written");
    property p_fs_wr;
        req.wr && req.addr == ADDR_FULL_SCALE |=> full_scale_code == $past(req.wdata);
    endproperty
    a_fs_wr: assert property (p_fs_wr) else $error("full scale not written");
    property p_bad_wr;
        req.wr && req.addr > ADDR_BRIGHT_HI |=> $stable(full_scale_code) && $stable(string_enable);
    endproperty
    a_bad_wr: assert property (p_bad_wr) else $error("unmapped write took effect");
    property p_conv; 1'b1 |=> converter_on == ($past(switch_freq_code) != 4'h0); endproperty
    a_conv: assert property (p_conv) else $error("converter state wrong");
    // ==========================================
    // fault pin
    property p_flt_lo; (|det) |-> ##2 (!fault_out_n_oe && !fault_out_n_o); endproperty
    a_flt_lo: assert property (p_flt_lo) else $error("fault pin not low");
    property p_flt_hi; (det == '0) |-> ##2 fault_out_n_oe; endproperty
    a_flt_hi: assert property (p_flt_hi) else $error("fault pin not released");
    c_read: cover property (rvalid);
    c_fault: cover property (!fault_out_n_oe);
    c_conv_off: cover property (!converter_on);
endmodule
bind bldc_regs bldc_regs_monitor u_mon (.clk, .rst, .req, .det, .rvalid, .string_enable,
    .overcurrent_recover_sel, .short_threshold_code, .switch_freq_code, .converter_on,
    .full_scale_code, .fault_out_n_o, .fault_out_n_oe);
`default_nettype wire

// [bench/tb_backlight_dimming_config_regs.sv]
// Purpose: self-checking bench for the register bank
// Assumes: 40 MHz clock, reset held 16 cycles
// Notes: fault pin modelled with a pull-up
`default_nettype none
module tb_backlight_dimming_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import bldc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pwm_in = 1'b0;
    bldc_det_t det = '0;
    bldc_req_t req;
    logic [7:0] rdata, fsc, d;
    logic [3:0] sen, sfc;
    logic [2:0] stc;
    logic [9:0] alv;
    logic rvalid, gate, ocs, conv, fo_o, fo_oe;
    int fails = 0;
    int cmp_count = 0;
    wire fault_pin = fo_oe ? 1'b1 : fo_o;
    // ==========================================
    // design and host
    bldc_regs dut (.clk(clk), .rst(rst), .req(req), .det(det), .pwm_in(pwm_in),
        .rdata(rdata), .rvalid(rvalid), .string_enable(sen), .string_gate(gate),
        .analog_level(alv), .overcurrent_recover_sel(ocs), .short_threshold_code(stc),
        .switch_freq_code(sfc), .converter_on(conv), .full_scale_code(fsc),
        .fault_out_n_o(fo_o), .fault_out_n_oe(fo_oe));
    bldc_host_model u_host (.clk(clk), .rvalid(rvalid), .rdata(rdata), .req(req));
    // 25 ns clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // ==========================================
    // compare helpers
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        u_host.rd(a, d);
        chk($sformatf("reg%0d", a), {2'h0, e}, {2'h0, d});
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        logic [7:0] rv [6];
        rv = '{8'hF0, 8'h44, 8'h3B, 8'h03, 8'h7F, 8'h00};
        for (int a = 0; a < 6; a++) begin
            rchk(3'(a), rv[a]);
        end
        chk("sw_out", 10'h044, {2'h0, ocs, stc, sfc});
        chk("fsc", 10'h03B, {2'h0, fsc});
        chk("en", 10'h00F, {6'h0, sen});
        chk("conv_pin", 10'h003, {8'h0, conv, fault_pin});
    endtask
    task automatic t_write();
        u_host.wr(ADDR_DIM_MODE, 8'h5B);
        rchk(ADDR_DIM_MODE, 8'h53);
        chk("en", 10'h005, {6'h0, sen});
        u_host.wr(ADDR_SWITCH, 8'h85);
        rchk(ADDR_SWITCH, 8'h85);
        chk("sw_out", 10'h085, {2'h0, ocs, stc, sfc});
        u_host.wr(ADDR_SWITCH, 8'h70);
        @(negedge clk);
        chk("conv", 10'h000, {9'h0, conv});
        u_host.wr(ADDR_FULL_SCALE, 8'hFF);
        u_host.wr(3'h7, 8'h00);
        rchk(ADDR_FULL_SCALE, 8'hFF);
        rchk(3'h7, 8'h00);
        u_host.wr(ADDR_FAULT, 8'hFC);
        rchk(ADDR_FAULT, 8'h00);
        u_host.wr(ADDR_FAULT, 8'h03);
        rchk(ADDR_FAULT, 8'h03);
    endtask
    task automatic t_faults();
        for (int i = 0; i < 6; i++) begin
            det = bldc_det_t'(6'h01 << i);
            repeat (3) @(negedge clk);
            chk("pin", 10'h000, {9'h0, fault_pin});
            rchk(ADDR_FAULT, {det, 2'h3});
            det = '0;
            repeat (3) @(negedge clk);
            chk("pin", 10'h001, {9'h0, fault_pin});
        end
    endtask
    task automatic t_dim();
        logic [27:0] rw [6];
        rw = '{{8'hF5, 8'hFF, 2'h3, 10'h3FF}, {8'hF5, 8'h10, 2'h0, 10'h040},
            {8'hF6, 8'h40, 2'h0, 10'h3FF}, {8'hF6, 8'h40, 2'h1, 10'h101},
            {8'hF7, 8'h80, 2'h0, 10'h3FF}, {8'hF7, 8'h80, 2'h1, 10'h201}};
        for (int k = 0; k < 6; k++) begin
            u_host.wr(ADDR_DIM_MODE, rw[k][27:20]);
            u_host.wr(ADDR_BRIGHT_HI, rw[k][19:12]);
            u_host.wr(ADDR_FAULT, {6'h0, rw[k][11:10]});
            repeat (4) @(negedge clk);
            chk("level", rw[k][9:0], alv);
        end
        chk("gate", 10'h001, {9'h0, gate});
        u_host.wr(ADDR_DIM_MODE, 8'hF0);
        for (int k = 0; k < 4; k++) begin
            pwm_in = k[0];
            repeat (4) @(negedge clk);
            chk("gate", {9'h0, k[0]}, {9'h0, gate});
        end
    endtask
    task automatic t_int_pwm();
        int hi;
        int rises;
        logic prev;
        hi = 0;
        rises = 0;
        u_host.wr(ADDR_DIM_MODE, 8'hF4);
        u_host.wr(ADDR_BRIGHT_HI, 8'h80);
        u_host.wr(ADDR_FAULT, 8'h00);
        repeat (DIM_PERIOD_CYC) @(negedge clk);
        prev = gate;
        repeat (4 * DIM_PERIOD_CYC) begin
            @(negedge clk);
            hi += int'(gate === 1'b1);
            rises += int'(gate === 1'b1 && prev === 1'b0);
            prev = gate;
        end
        chk("rises", 10'h004, 10'(rises));
        chk("duty", 10'h001, {9'h0, hi > 2 * DIM_PERIOD_CYC - 10 &&
            hi < 2 * DIM_PERIOD_CYC + 10});
    endtask
    // external source: 50 percent input duty through analog and mixed modes
    task automatic t_ext_dim();
        pwm_in = 1'b0;
        u_host.wr(ADDR_DIM_MODE, 8'hF1);
        repeat (4) begin
            pwm_in = 1'b1;
            repeat (4) @(negedge clk);
            pwm_in = 1'b0;
            repeat (4) @(negedge clk);
        end
        chk("ext_level", 10'h1FF, alv);
        chk("ext_gate", 10'h001, {9'h0, gate});
        u_host.wr(ADDR_DIM_MODE, 8'hF2);
        repeat (2) @(negedge clk);
        chk("mix25_level", 10'h1FF, alv);
        u_host.wr(ADDR_DIM_MODE, 8'hF3);
        repeat (2) @(negedge clk);
        chk("mix50_level", 10'h3FF, alv);
        chk("mix50_gate", 10'h000, {9'h0, gate});
    endtask
    // ==========================================
    // verdict, main sequence, watchdog
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_write();
        t_faults();
        t_dim();
        t_ext_dim();
        t_int_pwm();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// [hdl/bldc_duty_meter.sv]
// Purpose: measures the duty of the external pwm input as a 10-bit fraction
// Assumes: pwm input synchronous to clk, period under 2^16 cycles
// Notes: result updates on each rising edge of the input except one seen on the first clock after reset
`default_nettype none
module bldc_duty_meter (
    input wire logic clk,
    input wire logic rst,
    input wire logic pwm_in,
    output logic [9:0] duty
);
    import bldc_pkg::*;
    logic prev_ff;
    logic [15:0] period_ff;
    logic [15:0] high_ff;
    logic [25:0] scaled;
    logic [25:0] divisor;
    // ======================================================
    // edge tracking and counting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_ff <= 1'b0;
            period_ff <= 16'h0000;
            high_ff <= 16'h0000;
            duty <= 10'h000;
        end else begin
            prev_ff <= pwm_in;
            if (pwm_in && !prev_ff) begin
                if (period_ff != 16'h0000) begin
                    duty <= scaled[9:0];
                end
                period_ff <= 16'h0001;
                high_ff <= 16'h0001;
            end else begin
                if (period_ff != 16'hFFFF) begin
                    period_ff <= period_ff + 16'h0001;
                end
                if (pwm_in && high_ff != 16'hFFFF) begin
                    high_ff <= high_ff + 16'h0001;
                end
            end
        end
    end
    // high time scaled to full brightness, zero period only right after reset
    always_comb begin
        divisor = {10'h000, period_ff};
        if (period_ff == 16'h0000) begin
            divisor = 26'h0000001; // keeps the divide defined on the first clock after reset
        end
        scaled = ({10'h000, high_ff} * 26'(BRIGHT_FULL)) / divisor;
        if (high_ff >= period_ff) begin
            scaled = 26'(BRIGHT_FULL);
        end
    end
endmodule
`default_nettype wire

// [hdl/bldc_pkg.sv]
// Purpose: shared constants and types for the backlight dimming register bank
// Assumes: one 40 MHz system clock
// Notes: offsets are register indices on the byte-wide register port
`default_nettype none
package bldc_pkg;
    // ======================================================
    // register offsets
    localparam logic [2:0] ADDR_DIM_MODE = 3'h0;
    localparam logic [2:0] ADDR_SWITCH = 3'h1;
    localparam logic [2:0] ADDR_FULL_SCALE = 3'h2;
    localparam logic [2:0] ADDR_FAULT = 3'h3;
    localparam logic [2:0] ADDR_BRIGHT_HI = 3'h4;
    // reset values
    localparam logic [3:0] RST_STRING_EN = 4'hF;
    localparam logic RST_DIM_SRC = 1'b0;
    localparam logic [1:0] RST_DIM_MODE = 2'h0;
    localparam logic RST_OC_RECOVER = 1'b0;
    localparam logic [2:0] RST_SHORT_CODE = 3'h4;
    localparam logic [3:0] RST_FREQ_CODE = 4'h4;
    localparam logic [7:0] RST_FULL_SCALE = 8'h3B;
    localparam logic [1:0] RST_BRIGHT_LO = 2'h3;
    localparam logic [7:0] RST_BRIGHT_HI = 8'h7F;
    // field positions
    localparam int POS_STRING_EN = 4;
    localparam int POS_DIM_SRC = 2;
    localparam int POS_OC_RECOVER = 7;
    localparam int POS_SHORT_CODE = 4;
    localparam int POS_FAULT_FLAGS = 2;
    // timing: internal dimming pwm at 23 kHz
    localparam int CLK_HZ = 40000000;
    localparam int DIM_PWM_HZ = 23000;
    localparam int DIM_PERIOD_CYC = CLK_HZ / DIM_PWM_HZ;
    localparam logic [9:0] BRIGHT_FULL = 10'h3FF;
    // mixed-mode thresholds on a 10-bit duty
    localparam logic [9:0] THRESH_25 = 10'h100;
    localparam logic [9:0] THRESH_50 = 10'h200;
    // dimming behaviours
    typedef enum logic [1:0] {
        BLDC_DIM_PWM = 2'h0,
        BLDC_DIM_ANALOG = 2'h1,
        BLDC_DIM_MIX25 = 2'h2,
        BLDC_DIM_MIX50 = 2'h3
    } bldc_mode_t;
    // register-port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } bldc_req_t;
    // protection detector inputs
    typedef struct packed {
        logic diode_open;
        logic overvoltage;
        logic overcurrent;
        logic string_short;
        logic string_open;
        logic overtemp;
    } bldc_det_t;
endpackage
`default_nettype wire

// [hdl/bldc_pwm_gen.sv]
// Purpose: fixed-frequency internal dimming pwm
// Assumes: 40 MHz clock
// Notes: duty 3FF gives full on
`default_nettype none
module bldc_pwm_gen (
    input wire logic clk,
    input wire logic rst,
    input wire logic [9:0] duty,
    output logic pwm_out
);
    import bldc_pkg::*;
    logic [10:0] cnt_ff;
    logic [20:0] thresh;
    // ======================================================
    // period counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 11'h000;
        end else if (cnt_ff == 11'(DIM_PERIOD_CYC - 1)) begin
            cnt_ff <= 11'h000;
        end else begin
            cnt_ff <= cnt_ff + 11'h001;
        end
    end
    assign thresh = (21'(duty) * 21'(DIM_PERIOD_CYC)) / 21'(BRIGHT_FULL);
    // compare output
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (21'(cnt_ff) < thresh);
        end
    end
endmodule
`default_nettype wire

// [hdl/bldc_regs.sv]
// Purpose: configuration and status register bank of a four-string backlight controller
// Assumes: byte register port from an external serial slave, synchronous to clk
// Notes: analog current, converter and comparators live outside this block
`default_nettype none
// Summary of operation
// - each string enable bit switches its own current source on or off
// - bit 2 picks external pwm pin at 0, internal brightness at 1
// - two-bit dimming behaviour field at bits 1:0, resets to 00
// - mode 00 external: current gate copies input pwm duty
// - mode 00 internal: own pwm with 10-bit brightness duty
// - internal dimming pwm runs at fixed 23 kHz
// - mode 01: current always on, amplitude follows duty
// - mode 10: analog above 25 percent duty, pwm otherwise
// - mode 11: analog above 50 percent duty, pwm otherwise
// - bit 7 selects latch-off at 0, self-recovering at 1
// - three-bit short threshold, 4V plus 1V per step, resets 100b
// - four-bit frequency code, 0 is off, 100kHz per step, resets 0100b
// - eight-bit full scale code, 2 to 100 percent, resets 3Bh
// - diode open bit 7, overvoltage bit 6, overcurrent bit 5, reset 0
// - string short bit 4, string open bit 3, overtemp bit 2, reset 0
// - fault register bits 1:0 hold brightness low bits, reset 11b
// - string enables at bits 7:4, all reset enabled
// - upper eight brightness bits in own register, reset 7Fh
// - open-drain fault output pulled low while any fault present
module bldc_regs (
    input wire logic clk,
    input wire logic rst,
    input wire bldc_pkg::bldc_req_t req,
    input wire bldc_pkg::bldc_det_t det,
    input wire logic pwm_in,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic [3:0] string_enable,
    output logic string_gate,
    output logic [9:0] analog_level,
    output logic overcurrent_recover_sel,
    output logic [2:0] short_threshold_code,
    output logic [3:0] switch_freq_code,
    output logic converter_on,
    output logic [7:0] full_scale_code,
    output logic fault_out_n_o,
    output logic fault_out_n_oe
);
    import bldc_pkg::*;

    // ======================================================
    // register storage
    logic dim_src_ff;
    bldc_mode_t dim_behaviour_sel_ff;
    logic [1:0] brightness_low_bits_ff;
    logic [7:0] brightness_high_bits_ff;
    bldc_det_t flags_ff;
    logic [9:0] brightness;
    logic [9:0] ext_duty;
    logic [9:0] duty;
    logic int_pwm;
    logic pwm_src;
    logic use_analog;
    logic [7:0] nxt_rdata;

    // ======================================================
    // configuration writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            string_enable <= RST_STRING_EN;
            dim_src_ff <= RST_DIM_SRC;
            dim_behaviour_sel_ff <= bldc_mode_t'(RST_DIM_MODE);
            overcurrent_recover_sel <= RST_OC_RECOVER;
            short_threshold_code <= RST_SHORT_CODE;
            switch_freq_code <= RST_FREQ_CODE;
            full_scale_code <= RST_FULL_SCALE;
            brightness_low_bits_ff <= RST_BRIGHT_LO;
            brightness_high_bits_ff <= RST_BRIGHT_HI;
        end else if (req.wr) begin
            unique case (req.addr)
                ADDR_DIM_MODE: begin
                    string_enable <= req.wdata[POS_STRING_EN +: 4];
                    dim_src_ff <= req.wdata[POS_DIM_SRC];
                    dim_behaviour_sel_ff <= bldc_mode_t'(req.wdata[1:0]);
                end
                ADDR_SWITCH: begin
                    overcurrent_recover_sel <= req.wdata[POS_OC_RECOVER];
                    short_threshold_code <= req.wdata[POS_SHORT_CODE +: 3];
                    switch_freq_code <= req.wdata[3:0];
                end
                ADDR_FULL_SCALE: begin
                    full_scale_code <= req.wdata;
                end
                ADDR_FAULT: begin
                    brightness_low_bits_ff <= req.wdata[1:0];
                end
                ADDR_BRIGHT_HI: begin
                    brightness_high_bits_ff <= req.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // fault flags track detectors, host writes have no effect
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= det;
        end
    end

    // converter running unless frequency code is zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            converter_on <= 1'b1;
        end else begin
            converter_on <= (switch_freq_code != 4'h0);
        end
    end

    // open-drain fault pin, enable low while driving low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_out_n_o <= 1'b0;
            fault_out_n_oe <= 1'b1;
        end else begin
            fault_out_n_o <= 1'b0;
            fault_out_n_oe <= ~(|flags_ff);
        end
    end

    // ======================================================
    // dimming path
    assign brightness = {brightness_high_bits_ff, brightness_low_bits_ff};
    assign duty = dim_src_ff ? brightness : ext_duty;

    bldc_duty_meter u_meter (
        .clk(clk),
        .rst(rst),
        .pwm_in(pwm_in),
        .duty(ext_duty)
    );

    bldc_pwm_gen u_pwm (
        .clk(clk),
        .rst(rst),
        .duty(brightness),
        .pwm_out(int_pwm)
    );

    // pwm source: raw pin or internal generator
    assign pwm_src = dim_src_ff ? int_pwm : pwm_in;

    // analog or pwm selection by behaviour
    always_comb begin
        unique case (dim_behaviour_sel_ff)
            BLDC_DIM_PWM: use_analog = 1'b0;
            BLDC_DIM_ANALOG: use_analog = 1'b1;
            BLDC_DIM_MIX25: use_analog = (duty > THRESH_25);
            BLDC_DIM_MIX50: use_analog = (duty > THRESH_50);
        endcase
    end

    // current gate and amplitude
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            string_gate <= 1'b0;
            analog_level <= 10'h000;
        end else if (use_analog) begin
            string_gate <= 1'b1;
            analog_level <= duty;
        end else begin
            string_gate <= pwm_src;
            analog_level <= BRIGHT_FULL;
        end
    end

    // ======================================================
    // read path
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (req.addr)
            ADDR_DIM_MODE: nxt_rdata = {string_enable, 1'b0, dim_src_ff,
                dim_behaviour_sel_ff};
            ADDR_SWITCH: nxt_rdata = {overcurrent_recover_sel, short_threshold_code,
                switch_freq_code};
            ADDR_FULL_SCALE: nxt_rdata = full_scale_code;
            ADDR_FAULT: nxt_rdata = {flags_ff, brightness_low_bits_ff};
            ADDR_BRIGHT_HI: nxt_rdata = brightness_high_bits_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    // registered read answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= nxt_rdata;
            end
        end
    end
endmodule
`default_nettype wire
